// [scf_cfg.svh]
// Purpose: Constants for the target-side command front end
// Assumes: 10 MHz core clock
// Notes:   Offsets and codes used by scf_front_end
`ifndef SCF_CFG_SVH
`define SCF_CFG_SVH
`define SCF_OP_TUR        8'h00
`define SCF_OP_REQ_SENSE  8'h03
`define SCF_OP_INQUIRY    8'h12
`define SCF_OP_MODE_SEL   8'h15
`define SCF_OP_RESERVE    8'h16
`define SCF_OP_RELEASE    8'h17
`define SCF_OP_SCAN       8'h18
`define SCF_OP_MODE_SENSE 8'h1A
`define SCF_OP_DIAG       8'h1D
`define SCF_OP_SET_WINDOW 8'h24
`define SCF_OP_READ       8'h28
`define SCF_OP_SEND       8'h2A
`define SCF_OP_OBJ_POS    8'h31
`define SCF_OP_ENDORSER   8'hC1
`define SCF_ST_GOOD       8'h00
`define SCF_ST_CHECK      8'h02
`define SCF_KEY_NONE      4'h0
`define SCF_KEY_ILLEGAL   4'h5
`define SCF_ASC_NONE      8'h00
`define SCF_ASC_BAD_FIELD 8'h24
`define SCF_ASC_BAD_OP    8'h20
`define SCF_ASC_BAD_LUN   8'h25
`define SCF_MSG_COMPLETE  8'h00
`define SCF_MSG_DISCONN   8'h04
`define SCF_CDB_LEN6      3'h6
`define SCF_CDB_LEN10     3'h2
`define SCF_QUAL_BAD_LUN  3'h3
`define SCF_RESET_HARD    1'h0
`endif

// [scf_pkg.sv]
// Purpose: Types for the target-side command front end
// Assumes: Constants live in scf_cfg.svh
// Notes:   Phase set covers the target's view of the bus
package scf_pkg;
  typedef enum logic [3:0] {
    SCF_FREE, SCF_SELECT, SCF_COMMAND, SCF_DATA_IN, SCF_DATA_OUT,
    SCF_STATUS, SCF_MSG_IN, SCF_MSG_OUT
  } scf_phase_t;
endpackage

// [scf_front_end.sv]
// Purpose: Target-side bus condition handling, phase order and CDB checking
// Assumes: Byte handshakes and selection timing live outside; inputs are synchronous
// Notes:   Byte strobes are one-cycle pulses from the handshake engine
// Function
// - Attention seen lets the target enter message-out to collect the message; the code honours it only in selection.
// - Reset held on the bus overrides every phase and condition.
// - After reset, release all bus lines except reset at once.
// - Reset always leads to bus free; any phase may fall to bus free.
// - Reset aborts processes, drops reservation, restores defaults, sets unit attention.
// - Inquiry data reset-style flag reports the hard reset alternative.
// - Phases run bus free, arbitration, selection, then information phases; the code has no arbitration phase and goes from bus free straight to selection.
// - Connection ends with message-in complete or disconnect, then bus free.
// - First CDB byte is the operation code, last byte the control byte.
// - Nonzero reserved bits or codes end with check condition, illegal request.
// - Identify message logical unit overrides the CDB logical unit field.
// - Only unit zero; inquiry gives qualifier, others check except request sense.
// - Request sense to a bad unit reports illegal request, unit unsupported.
// - Transfer length counts one-byte blocks; zero moves no data.
// - Zero allocation length moves no data and is not an error.
// - Data-in ends at the lesser of allocation length and available data.
// - Control byte is wholly reserved; nonzero content is rejected.
// - Decode reserve, release, inquiry, request sense, diagnostic, test ready.
// - Decode set window, scan and read.
// - Decode send, object position, endorser, mode select and mode sense.
// - Phase lines: command C/D, data-in I/O, status both, message variants.
`timescale 1ns/100ps
`include "scf_cfg.svh"
module scf_front_end
  import scf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        bus_rst,
  input  wire logic        atn,
  input  wire logic        selected,
  input  wire logic        byte_done,
  input  wire logic [7:0]  byte_in,
  input  wire logic        ident_valid,
  input  wire logic [2:0]  ident_lun,
  input  wire logic        atn_msg_done,
  input  wire logic [23:0] data_avail,
  input  wire logic        disconnect_req,
  output logic             cd_out,
  output logic             io_out,
  output logic             msg_out,
  output logic             bsy_out,
  output logic             bus_oe,
  output logic [7:0]       op_code,
  output logic             cmd_valid,
  output logic [23:0]      xfer_count,
  output logic [7:0]       status_byte,
  output logic [7:0]       message_byte,
  output logic [3:0]       sense_key,
  output logic [7:0]       sense_code,
  output logic [2:0]       peripheral_qual,
  output logic             reset_style_flag,
  output logic             unit_attention,
  output logic             reserved_unit,
  output logic             params_default,
  output logic             abort_pulse
);

  typedef struct packed {
    scf_phase_t  phase;
    logic [2:0]  idx;
    logic [2:0]  cdb_len;
    logic [7:0]  op;
    logic [2:0]  lun;
    logic        lun_ident;
    logic        bad_field;
    logic        bad_op;
    logic [23:0] len;
    logic [23:0] count;
    logic        cd;
    logic        io;
    logic        msg;
    logic        bsy;
    logic        oe;
    logic        cmd_valid;
    logic [7:0]  status;
    logic [7:0]  message;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [2:0]  qual;
    logic        ua;
    logic        resv;
    logic        pdef;
    logic        abort;
  } scf_state_t;

  scf_state_t st;
  scf_state_t next_st;
  logic       known_op;
  logic       data_in_op;
  logic       data_out_op;
  logic       good_lun;
  logic [23:0] want;

  // Operation code decode; anything outside this set is treated as reserved
  always_comb begin
    unique case (st.op)
      `SCF_OP_TUR, `SCF_OP_RESERVE, `SCF_OP_RELEASE, `SCF_OP_DIAG,
      `SCF_OP_SCAN, `SCF_OP_ENDORSER, `SCF_OP_OBJ_POS: begin
        known_op = 1'b1;
        data_in_op = 1'b0;
        data_out_op = 1'b0;
      end
      `SCF_OP_INQUIRY, `SCF_OP_REQ_SENSE, `SCF_OP_MODE_SENSE,
      `SCF_OP_READ: begin
        known_op = 1'b1;
        data_in_op = 1'b1;
        data_out_op = 1'b0;
      end
      `SCF_OP_MODE_SEL, `SCF_OP_SET_WINDOW, `SCF_OP_SEND: begin
        known_op = 1'b1;
        data_in_op = 1'b0;
        data_out_op = 1'b1;
      end
      default: begin
        known_op = 1'b0;
        data_in_op = 1'b0;
        data_out_op = 1'b0;
      end
    endcase
  end

  // Unit from identify wins over the CDB field
  assign good_lun = (st.lun == 3'h0);
  // Data-in stops at whichever of length and available data is smaller
  assign want = (st.len < data_avail) ? st.len : data_avail;

  // Next-state logic for phases, CDB capture and checking
  always_comb begin
    next_st = st;
    next_st.abort = 1'b0;
    next_st.cmd_valid = 1'b0;
    unique case (st.phase)
      SCF_FREE: begin
        next_st.oe = 1'b0;
        next_st.bsy = 1'b0;
        if (selected) begin
          next_st.phase = SCF_SELECT;
          next_st.bsy = 1'b1;
          next_st.oe = 1'b1;
          next_st.lun_ident = 1'b0;
        end
      end
      SCF_SELECT: begin
        if (ident_valid) begin
          next_st.lun = ident_lun;
          next_st.lun_ident = 1'b1;
        end
        if (atn) begin
          next_st.phase = SCF_MSG_OUT;
        end else begin
          next_st.phase = SCF_COMMAND;
          next_st.idx = 3'h0;
          next_st.bad_field = 1'b0;
          next_st.len = 24'h0;
        end
      end
      SCF_MSG_OUT: begin
        if (ident_valid) begin
          next_st.lun = ident_lun;
          next_st.lun_ident = 1'b1;
        end
        if (atn_msg_done && !atn) begin
          next_st.phase = SCF_COMMAND;
          next_st.idx = 3'h0;
          next_st.bad_field = 1'b0;
          next_st.len = 24'h0;
        end
      end
      SCF_COMMAND: begin
        if (byte_done) begin
          next_st.idx = st.idx + 3'h1;
          if (st.idx == 3'h0) begin
            next_st.op = byte_in;
            next_st.cdb_len = (byte_in[7:5] == 3'h1) ? 3'h0 : `SCF_CDB_LEN6;
          end else if (st.idx == 3'h1) begin
            if (!st.lun_ident) begin
              next_st.lun = byte_in[7:5];
            end
            if (byte_in[4:0] != 5'h0 && st.op != `SCF_OP_INQUIRY) begin
              next_st.bad_field = 1'b1;
            end
            if (st.op == `SCF_OP_INQUIRY && byte_in[4:1] != 4'h0) begin
              next_st.bad_field = 1'b1;
            end
          end else if (st.idx + 3'h1 == st.cdb_len) begin
            if (byte_in != 8'h0) begin
              next_st.bad_field = 1'b1;
            end
          end else begin
            // Length fields sit in bytes 2..4 of six-byte CDBs
            next_st.len = {st.len[15:0], byte_in};
            if (st.op == `SCF_OP_TUR || st.op == `SCF_OP_RESERVE
                || st.op == `SCF_OP_RELEASE) begin
              if (byte_in != 8'h0) begin
                next_st.bad_field = 1'b1;
              end
            end
          end
          if (st.idx + 3'h1 == st.cdb_len && st.idx != 3'h0) begin
            next_st.cmd_valid = 1'b1;
            next_st.count = 24'h0;
            next_st.qual = good_lun ? 3'h0 : `SCF_QUAL_BAD_LUN;
            next_st.status = `SCF_ST_GOOD;
            next_st.phase = SCF_STATUS;
            if (!known_op) begin
              next_st.status = `SCF_ST_CHECK;
              next_st.key = `SCF_KEY_ILLEGAL;
              next_st.asc = `SCF_ASC_BAD_OP;
            end else if (next_st.bad_field) begin
              next_st.status = `SCF_ST_CHECK;
              next_st.key = `SCF_KEY_ILLEGAL;
              next_st.asc = `SCF_ASC_BAD_FIELD;
            end else if (!good_lun && st.op == `SCF_OP_REQ_SENSE) begin
              next_st.key = `SCF_KEY_ILLEGAL;
              next_st.asc = `SCF_ASC_BAD_LUN;
              next_st.phase = (next_st.len == 24'h0 || data_avail == 24'h0)
                              ? SCF_STATUS : SCF_DATA_IN;
            end else if (!good_lun && st.op != `SCF_OP_INQUIRY) begin
              next_st.status = `SCF_ST_CHECK;
              next_st.key = `SCF_KEY_ILLEGAL;
              next_st.asc = `SCF_ASC_BAD_LUN;
            end else begin
              if (st.op == `SCF_OP_RESERVE) next_st.resv = 1'b1;
              if (st.op == `SCF_OP_RELEASE) next_st.resv = 1'b0;
              if (st.op == `SCF_OP_MODE_SEL) next_st.pdef = 1'b0;
              if (st.op == `SCF_OP_REQ_SENSE) begin
                next_st.key = `SCF_KEY_NONE;
                next_st.asc = `SCF_ASC_NONE;
              end
              // Zero length moves no data and is not an error
              if (next_st.len != 24'h0 && data_avail != 24'h0 && data_in_op) begin
                next_st.phase = SCF_DATA_IN;
              end else if (next_st.len != 24'h0 && data_out_op) begin
                next_st.phase = SCF_DATA_OUT;
              end
              if (st.op != `SCF_OP_INQUIRY) next_st.ua = 1'b0;
            end
          end
        end
      end
      SCF_DATA_IN: begin
        // Leave on the byte that reaches the limit; a lingering data phase
        // would make the handshake engine start one byte too many
        if (st.count >= want) begin
          next_st.phase = SCF_STATUS;
        end else if (byte_done) begin
          next_st.count = st.count + 24'h1;
          if (st.count + 24'h1 >= want) begin
            next_st.phase = SCF_STATUS;
          end
        end
      end
      SCF_DATA_OUT: begin
        // Same early exit as data-in, bounded by the transfer length
        if (st.count >= st.len) begin
          next_st.phase = SCF_STATUS;
        end else if (byte_done) begin
          next_st.count = st.count + 24'h1;
          if (st.count + 24'h1 >= st.len) begin
            next_st.phase = SCF_STATUS;
          end
        end
      end
      SCF_STATUS: begin
        if (byte_done) begin
          next_st.phase = SCF_MSG_IN;
          next_st.message = disconnect_req ? `SCF_MSG_DISCONN : `SCF_MSG_COMPLETE;
        end
      end
      SCF_MSG_IN: begin
        if (byte_done) begin
          next_st.phase = SCF_FREE;
          // Busy drops with the phase so the bus is free in the same edge
          next_st.bsy = 1'b0;
          next_st.oe = 1'b0;
        end
      end
      default: begin
        // Illegal phase code falls back to a released bus
        next_st.phase = SCF_FREE;
        next_st.bsy = 1'b0;
        next_st.oe = 1'b0;
      end
    endcase
    // Phase line encoding follows the phase that will be shown
    next_st.cd = (next_st.phase == SCF_COMMAND) || (next_st.phase == SCF_STATUS)
                 || (next_st.phase == SCF_MSG_IN) || (next_st.phase == SCF_MSG_OUT);
    next_st.io = (next_st.phase == SCF_DATA_IN) || (next_st.phase == SCF_STATUS)
                 || (next_st.phase == SCF_MSG_IN);
    next_st.msg = (next_st.phase == SCF_MSG_IN) || (next_st.phase == SCF_MSG_OUT);
    // Bus reset overrides everything; lines drop in the same edge
    if (bus_rst) begin
      next_st.phase = SCF_FREE;
      next_st.cd = 1'b0;
      next_st.io = 1'b0;
      next_st.msg = 1'b0;
      next_st.bsy = 1'b0;
      next_st.oe = 1'b0;
      next_st.abort = 1'b1;
      next_st.resv = 1'b0;
      next_st.pdef = 1'b1;
      next_st.ua = 1'b1;
      next_st.count = 24'h0;
      next_st.idx = 3'h0;
    end
  end

  // State register; reset gives a quiet bus with defaults in place
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.phase <= SCF_FREE;
      st.ua <= 1'b1;
      st.pdef <= 1'b1;
      st.cdb_len <= `SCF_CDB_LEN6;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops, except the reset style flag tied to SCF_RESET_HARD
  assign cd_out = st.cd;
  assign io_out = st.io;
  assign msg_out = st.msg;
  assign bsy_out = st.bsy;
  assign bus_oe = st.oe;
  assign op_code = st.op;
  assign cmd_valid = st.cmd_valid;
  assign xfer_count = st.count;
  assign status_byte = st.status;
  assign message_byte = st.message;
  assign sense_key = st.key;
  assign sense_code = st.asc;
  assign peripheral_qual = st.qual;
  assign reset_style_flag = `SCF_RESET_HARD;
  assign unit_attention = st.ua;
  assign reserved_unit = st.resv;
  assign params_default = st.pdef;
  assign abort_pulse = st.abort;

endmodule

// [scf_front_end_chk.sv]
// Purpose: Concurrent checks on the command front end ports
// Assumes: One clock domain, srst synchronous active high
// Notes:   Bound to every scf_front_end instance below
`timescale 1ns/100ps
module scf_front_end_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       bus_rst,
  input wire logic       selected,
  input wire logic       byte_done,
  input wire logic       cd_out,
  input wire logic       io_out,
  input wire logic       msg_out,
  input wire logic       bsy_out,
  input wire logic       bus_oe,
  input wire logic       cmd_valid,
  input wire logic       abort_pulse,
  input wire logic       unit_attention,
  input wire logic       reserved_unit,
  input wire logic       params_default,
  input wire logic       reset_style_flag,
  input wire logic [2:0] peripheral_qual
);
  // All checks share the core clock and the core reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  rst_idle_a: assert property (bus_rst |=> !cd_out && !io_out && !msg_out && !bsy_out && !bus_oe)
    else $error("bus lines not released after bus reset");
  rst_abort_a: assert property ($rose(bus_rst) |=> abort_pulse ##1 !abort_pulse)
    else $error("abort pulse missing or too long");
  hard_reset_a: assert property (bus_rst |=> unit_attention && !reserved_unit && params_default)
    else $error("hard reset effects missing");
  abort_cause_a: assert property (abort_pulse |-> $past(bus_rst))
    else $error("abort pulse without bus reset");
  style_flag_a: assert property (reset_style_flag == 1'h0)
    else $error("reset style flag not hard");
  phase_code_a: assert property (msg_out |-> cd_out)
    else $error("reserved phase code driven");
  lines_drive_a: assert property ((cd_out || io_out || msg_out) |-> bsy_out && bus_oe)
    else $error("phase lines driven while not connected");
  select_a: assert property (selected && !bsy_out && !bus_rst |=> bsy_out)
    else $error("selection not answered");
  msg_end_a: assert property (cd_out && io_out && msg_out && byte_done && !bus_rst
    |=> !bsy_out && !cd_out)
    else $error("message in not followed by bus free");
  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command valid longer than one cycle");
  qual_code_a: assert property (peripheral_qual == 3'h0 || peripheral_qual == 3'h3)
    else $error("unexpected peripheral qualifier");
  cover property (cmd_valid);
  cover property (abort_pulse);
  cover property (cd_out && msg_out && !io_out);
  cover property (io_out && !cd_out && !msg_out);
endmodule
bind scf_front_end scf_front_end_chk scf_front_end_chk_i (.core_clk(core_clk), .srst(srst),
  .bus_rst(bus_rst), .selected(selected), .byte_done(byte_done), .cd_out(cd_out),
  .io_out(io_out), .msg_out(msg_out), .bsy_out(bsy_out), .bus_oe(bus_oe),
  .cmd_valid(cmd_valid), .abort_pulse(abort_pulse), .unit_attention(unit_attention),
  .reserved_unit(reserved_unit), .params_default(params_default),
  .reset_style_flag(reset_style_flag), .peripheral_qual(peripheral_qual));

// [scf_initiator.sv]
// Purpose: Behavioural initiator that selects the target and serves every phase
// Assumes: Byte strobes are one-cycle pulses, inputs change at the rising edge
// Notes:   Released data lines toggle so a stale byte is never mistaken for a held one
`timescale 1ns/100ps
module scf_initiator (
  input  wire logic       core_clk,
  input  wire logic       cd_out,
  input  wire logic       io_out,
  input  wire logic       msg_out,
  input  wire logic       bsy_out,
  output logic            selected,
  output logic            byte_done,
  output logic            atn,
  output logic            ident_valid,
  output logic            atn_msg_done,
  output logic [7:0]      byte_in,
  output logic [2:0]      ident_lun
);
  logic [7:0] cdb [0:9];
  int         n_data;
  initial begin
    {selected, byte_done, atn, ident_valid, atn_msg_done, ident_lun} = '0;
    byte_in = 8'h00;
  end
  // One connection: select, then follow whatever phase the target shows
  task automatic serve(input logic use_atn, input logic idv, input logic [2:0] lun);
    int idx;
    int guard;
    idx = 0;
    n_data = 0;
    @(posedge core_clk);
    selected <= 1'b1;
    ident_valid <= idv;
    ident_lun <= lun;
    atn_msg_done <= 1'b0;
    @(posedge core_clk);
    selected <= 1'b0;
    // Attention only once the bus has left bus free
    atn <= use_atn;
    // Identify stands through the selection cycle, which shows no phase lines
    @(posedge core_clk);
    ident_valid <= 1'b0;
    for (guard = 0; guard < 3000; guard++) begin
      @(posedge core_clk);
      if (byte_done) begin
        byte_done <= 1'b0;
        byte_in <= ~byte_in;
      end else if (!bsy_out && guard > 2) begin
        break;
      end else if (bsy_out) begin
        case ({msg_out, cd_out, io_out})
          3'b010: begin
            byte_in <= cdb[idx];
            byte_done <= 1'b1;
            idx++;
          end
          3'b001, 3'b000: begin
            n_data++;
            byte_done <= 1'b1;
          end
          3'b110: begin
            atn <= 1'b0;
            atn_msg_done <= 1'b1;
          end
          3'b011, 3'b111: byte_done <= 1'b1;
          default: ;
        endcase
      end
    end
    byte_done <= 1'b0;
    atn <= 1'b0;
  endtask
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the command front end
// Assumes: Expectations come from the integer model in run
// Notes:   Only six and eight byte slots are used, matching the decoder
`timescale 1ns/100ps
module tb;
  import scf_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, bus_rst = 1'b0;
  logic [23:0] data_avail = 24'h0;
  logic disconnect_req = 1'b0;
  logic selected, byte_done, atn, ident_valid, atn_msg_done, cd_out, io_out, msg_out;
  logic bsy_out, bus_oe, cmd_valid, reset_style_flag, unit_attention, reserved_unit;
  logic params_default, abort_pulse;
  logic [7:0] byte_in, op_code, status_byte, message_byte, sense_code, st_q, msg_q;
  logic [2:0] ident_lun, peripheral_qual;
  logic [3:0] sense_key;
  logic [23:0] xfer_count;
  int err_total = 0, total_checks = 0, seed = 32'h75ce;
  int ops [14] = '{8'h00, 8'h03, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1D,
                   8'h24, 8'h28, 8'h2A, 8'h31, 8'hC1};
  always #50 core_clk = ~core_clk;
  scf_front_end scf_front_end_i (.core_clk(core_clk), .srst(srst), .bus_rst(bus_rst),
    .atn(atn), .selected(selected), .byte_done(byte_done), .byte_in(byte_in),
    .ident_valid(ident_valid), .ident_lun(ident_lun), .atn_msg_done(atn_msg_done),
    .data_avail(data_avail), .disconnect_req(disconnect_req), .cd_out(cd_out),
    .io_out(io_out),
    .msg_out(msg_out), .bsy_out(bsy_out), .bus_oe(bus_oe), .op_code(op_code),
    .cmd_valid(cmd_valid), .xfer_count(xfer_count), .status_byte(status_byte),
    .message_byte(message_byte), .sense_key(sense_key), .sense_code(sense_code),
    .peripheral_qual(peripheral_qual), .reset_style_flag(reset_style_flag),
    .unit_attention(unit_attention), .reserved_unit(reserved_unit),
    .params_default(params_default), .abort_pulse(abort_pulse));
  scf_initiator scf_initiator_i (.core_clk(core_clk), .cd_out(cd_out), .io_out(io_out),
    .msg_out(msg_out), .bsy_out(bsy_out), .selected(selected), .byte_done(byte_done),
    .atn(atn), .ident_valid(ident_valid), .atn_msg_done(atn_msg_done),
    .byte_in(byte_in), .ident_lun(ident_lun));
  // Status and message bytes are captured while their phases stand
  always @(posedge core_clk) begin
    if (cd_out && io_out && !msg_out) st_q <= status_byte;
    if (cd_out && io_out && msg_out) msg_q <= message_byte;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One command through the model and the design, then compare status, message, data count and opcode, plus sense and qualifier where they apply
  task automatic run(input int op, b1, b4, ctl, input logic idv, input logic [2:0] lun);
    int st, key, code, n, ul;
    bit sup;
    sup = 0;
    foreach (ops[k]) if (ops[k] == op) sup = 1;
    ul = idv ? lun : b1 >> 5;
    n = 0;
    if (op inside {8'h03, 8'h12, 8'h1A, 8'h28}) n = b4 < data_avail ? b4 : data_avail;
    if (op inside {8'h15, 8'h24, 8'h2A}) n = b4;
    {st, key, code} = {32'h0, 32'h0, 32'h0};
    if (!sup) {st, key, code, n} = {32'h2, 32'h5, 32'h20, 32'h0};
    else if (ctl != 0 || (b1 & (op == 8'h12 ? 8'h1E : 8'h1F)) != 0)
      {st, key, code, n} = {32'h2, 32'h5, 32'h24, 32'h0};
    else if (ul != 0 && op == 8'h03) {key, code} = {32'h5, 32'h25};
    else if (ul != 0 && op != 8'h12) {st, key, code, n} = {32'h2, 32'h5, 32'h25, 32'h0};
    for (int i = 0; i < 10; i++) scf_initiator_i.cdb[i] = 8'h00;
    scf_initiator_i.cdb[0] = op[7:0];
    scf_initiator_i.cdb[1] = b1[7:0];
    scf_initiator_i.cdb[4] = b4[7:0];
    scf_initiator_i.cdb[(op >= 8'h20 && op < 8'h40) ? 7 : 5] = ctl[7:0];
    scf_initiator_i.serve(idv, idv, lun);
    chk(st_q, st[23:0]);
    chk(scf_initiator_i.n_data, n[23:0]);
    chk(msg_q, disconnect_req ? 24'h4 : 24'h0);
    chk(op_code, op[23:0]);
    chk(xfer_count, n[23:0]);
    if (st != 0 || op == 8'h03) chk({sense_key, sense_code}, {key[3:0], code[7:0]});
    if (op == 8'h12) chk(peripheral_qual, ul != 0 ? 24'h3 : 24'h0);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(reset_style_flag, 24'h0);
    data_avail <= 24'd36;
    run(8'h12, 0, 0, 0, 0, 3'h0);
    run(8'h12, 8'hA0, $unsigned($random(seed)) % 255 + 1, 0, 1, 3'h0);
    run(8'h12, 0, 40, 0, 1, 3'h3);
    run(8'h03, 8'h40, 18, 0, 0, 3'h0);
    run(8'h00, 8'h40, 0, 0, 0, 3'h0);
    run(8'h00, 8'h01, 0, 0, 0, 3'h0);
    foreach (ops[k]) run(ops[k], 0, 0, $unsigned($random(seed)) % 255 + 1, 0, 3'h0);
    repeat (4) run(8'h40 + $unsigned($random(seed)) % 64, 0, 0, 0, 0, 3'h0);
    // Reserve, then a parameter list in data-out ending with a disconnect
    run(8'h16, 0, 0, 0, 0, 3'h0);
    disconnect_req <= 1'b1;
    run(8'h15, 0, 4, 0, 0, 3'h0);
    disconnect_req <= 1'b0;
    chk({unit_attention, reserved_unit, params_default}, 24'h2);
    // Bus reset in the middle of the command phase
    fork
      scf_initiator_i.serve(1'b0, 1'b0, 3'h0);
      begin
        repeat (5) @(posedge core_clk);
        bus_rst <= 1'b1;
        @(posedge core_clk);
        bus_rst <= 1'b0;
        #1 chk({cd_out, io_out, msg_out, bsy_out, bus_oe, abort_pulse}, 24'h1);
        chk({unit_attention, reserved_unit, params_default}, 24'h5);
      end
    join
    // The target must take a fresh command after the reset
    run(8'h00, 0, 0, 0, 0, 3'h0);
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
endmodule
